/* File: verilog/isd_decode.sv */
`timescale 1ns/1ps
// Operation
// RQ1: Upper latchable address is taken as valid only while the latch enable is high.
// RQ2: Bus address is low 20 system bits joined with latched high bits.
// RQ3: Assert memory 16-bit size when segment holds a 16-bit window.
// RQ4: Unconnected latchable lines read low, so 8-bit slots work.
// RQ5: Drive data on memory read only for valid window hits.
// RQ6: System memory read acts like memory read.
// RQ7: Memory write hit latches data first, then issues write request.
// RQ8: System memory write acts like memory write.
// RQ9: Drive data on I/O read only for valid register hits.
// RQ10: Capture data on I/O write only for valid register hits.
// RQ11: Byte high enable low on 16-bit config uses upper byte lanes.
// RQ12: I/O cycles are answered only while address enable is low.
// RQ13: Refresh cycles are ignored: no drive, no local access.
// RQ14: Missing strobe lines read deasserted, giving only 8-bit transfers.
// RQ15: Pull channel ready low while a local memory access is pending.
// RQ16: Assert I/O 16-bit size on any I/O register access.
// RQ17: Data drivers stay off except during a valid addressed read.
module isd_decode
  import isd_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_clk,
  input wire logic bale,
  input wire logic [isd_pkg::SA_W-1:0] sa,
  input wire logic [isd_pkg::LA_W-1:0] la,
  input wire logic [isd_pkg::DATA_W-1:0] d_in,
  output logic [isd_pkg::DATA_W-1:0] d_out,
  output logic d_oe_lo,
  output logic d_oe_hi,
  input wire logic mem_rd_n,
  input wire logic sys_mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic sys_mem_wr_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic byte_hi_n,
  input wire logic aen,
  input wire logic refresh_n,
  output logic chan_rdy_oe,
  output logic mem16_oe,
  output logic io16_oe,
  input wire logic [isd_pkg::ADDR_W-1:0] win_base [isd_pkg::NUM_WIN],
  input wire logic [isd_pkg::ADDR_W-1:0] win_mask [isd_pkg::NUM_WIN],
  input wire logic [isd_pkg::NUM_WIN-1:0] win_en,
  input wire logic [isd_pkg::NUM_WIN-1:0] win_16,
  input wire logic slot_16,
  input wire logic [15:0] io_base,
  input wire logic [15:0] io_span,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [isd_pkg::ADDR_W-1:0] wr_addr,
  output logic [isd_pkg::DATA_W-1:0] wr_data,
  output logic wr_io,
  output logic rd_req,
  output logic [isd_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_io,
  input wire logic rd_done,
  input wire logic [isd_pkg::DATA_W-1:0] rd_data
);
  import isd_pkg::*;

  initial
  begin
    if (FIFO_DEPTH < 2)
      $error("isd_decode FIFO_DEPTH too small");
  end

  localparam int FW = ADDR_W + DATA_W + 1;
  localparam int NS = 13;

  // Synchronised bus inputs, two flops each
  typedef struct packed {
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [SA_W-1:0] sa1;
    logic [SA_W-1:0] sa2;
    logic [LA_W-1:0] la1;
    logic [LA_W-1:0] la2;
    logic [DATA_W-1:0] d1;
    logic [DATA_W-1:0] d2;
  } isd_sync_s;

  typedef struct packed {
    isd_state_e st;
    logic [LA_W-1:0] la_hold;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic hi;
    logic drive;
    logic chrdy_lo;
    logic m16;
    logic i16;
    logic push;
    logic [DATA_W-1:0] wdata;
    logic wio;
    logic rreq;
    logic rio;
    logic bclk_d;
  } isd_state_s;

  isd_sync_s sy_reg;
  isd_sync_s sy_next;
  isd_state_s s_reg;
  isd_state_s s_next;

  // Window hit on a full bus address
  function automatic logic [NUM_WIN-1:0] win_hit(input logic [ADDR_W-1:0] a);
    logic [NUM_WIN-1:0] h;
    h = '0;
    for (int i = 0; i < NUM_WIN; i++)
      h[i] = win_en[i] && ((a & ~win_mask[i]) == (win_base[i] & ~win_mask[i]));
    return h;
  endfunction

  // Segment match on the 128 KB boundary only
  function automatic logic seg16(input logic [LA_W-1:0] l);
    logic r;
    r = 1'b0;
    for (int i = 0; i < NUM_WIN; i++)
      if (win_en[i] && win_16[i] && win_base[i][ADDR_W-1:SEG_LSB] == l)
        r = 1'b1;
    return r;
  endfunction

  // Unpacked sync outputs, stage two only
  logic bclk_s;
  logic bale_s;
  logic mrd_s;
  logic mwr_s;
  logic iord_s;
  logic iowr_s;
  logic bhe_s;
  logic aen_s;
  logic ref_s;
  logic [SA_W-1:0] sa_s;
  logic [LA_W-1:0] la_s;
  logic [DATA_W-1:0] d_s;
  logic [ADDR_W-1:0] bus_addr;
  logic [15:0] io_off;
  logic mem_hit;
  logic io_hit;
  logic fifo_ready;

  always_comb
  begin
    sy_next.s1 = {bus_clk, bale, mem_rd_n, sys_mem_rd_n, mem_wr_n, sys_mem_wr_n,
      io_rd_n, io_wr_n, byte_hi_n, aen, refresh_n, 2'b00};
    sy_next.s2 = sy_reg.s1;
    sy_next.sa1 = sa;
    sy_next.sa2 = sy_reg.sa1;
    sy_next.la1 = la;
    sy_next.la2 = sy_reg.la1;
    sy_next.d1 = d_in;
    sy_next.d2 = sy_reg.d1;
  end

  // Strobes active low; the two memory read and write pairs merge here
  assign bclk_s = sy_reg.s2[12];
  assign bale_s = sy_reg.s2[11];
  assign mrd_s = !sy_reg.s2[10] || !sy_reg.s2[9]; // RQ6 RQ14
  assign mwr_s = !sy_reg.s2[8] || !sy_reg.s2[7]; // RQ8 RQ14
  assign iord_s = !sy_reg.s2[6];
  assign iowr_s = !sy_reg.s2[5];
  assign bhe_s = !sy_reg.s2[4]; // RQ14
  assign aen_s = sy_reg.s2[3];
  assign ref_s = !sy_reg.s2[2];
  assign sa_s = sy_reg.sa2;
  // Floating latchable lines are pulled low at the pad, so zeros decode as low memory
  assign la_s = sy_reg.la2; // RQ4
  assign d_s = sy_reg.d2;

  // Upper bits from the held latch value, lower from system lines
  assign bus_addr = {s_reg.la_hold[LA_W-1:LA_W-4], sa_s}; // RQ2
  assign io_off = sa_s[15:0] - io_base;
  assign mem_hit = |win_hit(bus_addr) && !ref_s; // RQ13
  assign io_hit = !aen_s && !ref_s && sa_s[15:0] >= io_base && io_off < io_span; // RQ12 RQ13

  always_comb
  begin
    s_next = s_reg;
    s_next.push = 1'b0;
    s_next.bclk_d = bclk_s;
    // Capture upper address only while latch enable is high
    if (bale_s)
      s_next.la_hold = la_s; // RQ1
    s_next.m16 = seg16(s_reg.la_hold) && !ref_s && slot_16; // RQ3
    case (s_reg.st)
      ISD_IDLE:
      begin
        s_next.drive = 1'b0;
        s_next.i16 = io_hit && (iord_s || iowr_s); // RQ16
        s_next.hi = bhe_s && slot_16; // RQ11
        if (mrd_s && mem_hit)
        begin
          s_next.addr = bus_addr;
          s_next.rio = 1'b0;
          s_next.rreq = 1'b1;
          s_next.chrdy_lo = 1'b1; // RQ15
          s_next.st = ISD_MRD;
        end
        else if (iord_s && io_hit)
        begin
          s_next.addr = {8'h00, io_off};
          s_next.rio = 1'b1;
          s_next.rreq = 1'b1;
          s_next.chrdy_lo = 1'b1; // RQ15
          s_next.st = ISD_IORD;
        end
        else if ((mwr_s && mem_hit) || (iowr_s && io_hit))
        begin
          // Data latched before any request goes out
          s_next.addr = mwr_s ? bus_addr : {8'h00, io_off};
          s_next.wio = !mwr_s;
          s_next.wdata = d_s; // RQ7 RQ10
          s_next.chrdy_lo = 1'b1; // RQ15
          s_next.st = mwr_s ? ISD_MWR : ISD_IOWR;
        end
      end
      ISD_MRD, ISD_IORD:
      begin
        if (rd_done)
        begin
          s_next.rreq = 1'b0;
          s_next.dout = rd_data;
          s_next.chrdy_lo = 1'b0;
          s_next.drive = 1'b1; // RQ5 RQ9
          s_next.st = ISD_WAIT;
        end
      end
      ISD_MWR, ISD_IOWR:
      begin
        // Queue stalls the bus via channel ready when full
        if (fifo_ready)
        begin
          s_next.push = 1'b1; // RQ7
          s_next.chrdy_lo = 1'b0;
          s_next.st = ISD_WAIT;
        end
      end
      ISD_WAIT:
      begin
        // Hold data until every read and write strobe is released
        if (!(mrd_s || iord_s || mwr_s || iowr_s))
        begin
          s_next.drive = 1'b0; // RQ17
          s_next.i16 = 1'b0;
          s_next.st = ISD_IDLE;
        end
      end
      default:
        s_next.st = ISD_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy_reg <= '{s1: {2'b00, 9'h1ff, 2'b00}, s2: {2'b00, 9'h1ff, 2'b00},
        sa1: '0, sa2: '0, la1: '0, la2: '0, d1: DATA_RST, d2: DATA_RST};
      s_reg <= '{st: ISD_IDLE, la_hold: '0, addr: ADDR_RST, dout: DATA_RST,
        wdata: DATA_RST, default: 1'b0};
    end
    else
    begin
      sy_reg <= sy_next;
      s_reg <= s_next;
    end
  end

  // Write queue toward the graphics processor
  isd_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_wq (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(s_reg.push),
    .in_ready(fifo_ready),
    .in_data({s_reg.wio, s_reg.addr, s_reg.wdata}),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_io, wr_addr, wr_data})
  );

  // Both lanes come from the read register; the enables decide which lanes reach the bus
  assign d_out = s_reg.dout;
  assign d_oe_lo = s_reg.drive && !ref_s; // RQ13 RQ17
  assign d_oe_hi = s_reg.drive && s_reg.hi && !ref_s; // RQ11 RQ17
  assign chan_rdy_oe = s_reg.chrdy_lo; // RQ15
  assign mem16_oe = s_reg.m16; // RQ3
  assign io16_oe = s_reg.i16; // RQ16
  assign rd_req = s_reg.rreq;
  assign rd_addr = s_reg.addr;
  assign rd_io = s_reg.rio;
endmodule

/* File: verilog/isd_pkg.sv */
package isd_pkg;
  // Bus widths and window count
  localparam int SA_W = 20;
  localparam int LA_W = 7;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int NUM_WIN = 4;
  // Segment size on the latchable lines: bits 23..17 select a 128 KB segment
  localparam int SEG_LSB = 17;
  // Latchable lines carry bits 17..23; low bits come from the system address
  localparam int LA_LSB = 17;
  // Reset values
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
  // Default I/O register base and span (bytes)
  localparam logic [15:0] IO_BASE_DEF = 16'h0290;
  localparam logic [15:0] IO_SPAN_DEF = 16'h0008;
  // Cycle kinds
  typedef enum logic [2:0] {
    ISD_IDLE, ISD_MRD, ISD_MWR, ISD_IORD, ISD_IOWR, ISD_WAIT
  } isd_state_e;
endpackage

/* File: verilog/isd_fifo.sv */
`timescale 1ns/1ps
module isd_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("isd_fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic push;
  logic pop;
  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_reg ^ rd_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_reg != rd_reg;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_reg[AW-1:0]];
  // Storage has no reset, pointers do
  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_reg[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + 1'b1;
      if (pop)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule

/* File: sim/isd_decode_asserts.sv */
`timescale 1ns/1ps
module isd_decode_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic mem_rd_n,
  input wire logic sys_mem_rd_n,
  input wire logic mem_wr_n,
  input wire logic sys_mem_wr_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  input wire logic byte_hi_n,
  input wire logic aen,
  input wire logic refresh_n,
  input wire logic slot_16,
  input wire logic d_oe_lo,
  input wire logic d_oe_hi,
  input wire logic chan_rdy_oe,
  input wire logic io16_oe,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [isd_pkg::DATA_W-1:0] wr_data
);
  import isd_pkg::*;
  logic [4:0] rd_hist;
  wire rd_any = !(mem_rd_n && sys_mem_rd_n && io_rd_n);
  wire st_any = rd_any || !(mem_wr_n && sys_mem_wr_n && io_wr_n);
  // Drivers lag the strobe release by the sync delay, so keep a short history
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      rd_hist <= 5'h00;
    else
      rd_hist <= {rd_hist[3:0], rd_any};
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_wr_start;
    $rose(chan_rdy_oe) && !(mem_wr_n && sys_mem_wr_n);
  endsequence
  sequence s_push;
    ##[1:300] wr_valid;
  endsequence
  sequence s_ref_rd;
    (!refresh_n && !(mem_rd_n && sys_mem_rd_n)) [*5];
  endsequence
  sequence s_aen_io;
    (aen && !(io_rd_n && io_wr_n)) [*5];
  endsequence
  a_read_drive: assert property (d_oe_lo |-> rd_any || rd_hist != 5'h00)
    else $error("data driven outside a read");
  a_refresh_quiet: assert property (s_ref_rd |-> !d_oe_lo && !chan_rdy_oe)
    else $error("refresh cycle answered");
  a_aen_ignore: assert property (s_aen_io |-> !d_oe_lo && !io16_oe && !chan_rdy_oe)
    else $error("io cycle answered with aen high");
  a_rdy_cause: assert property ($rose(chan_rdy_oe) |-> st_any)
    else $error("ready pulled without a strobe");
  a_rdy_bound: assert property (chan_rdy_oe |-> ##[1:300] !chan_rdy_oe)
    else $error("ready held too long");
  a_wr_push: assert property (s_wr_start |-> s_push)
    else $error("write not forwarded");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_data))
    else $error("write request dropped");
  a_io16_aen: assert property (io16_oe |-> !aen)
    else $error("io size with aen high");
  a_hi_lane: assert property (d_oe_hi |-> slot_16 && !byte_hi_n)
    else $error("high lane driven");
endmodule

/* File: sim/isd_host.sv */
`timescale 1ns/1ps
module isd_host (
  input wire logic clock,
  input wire logic chan_rdy_oe,
  input wire logic mem16_oe,
  input wire logic io16_oe,
  output logic bale,
  output logic [isd_pkg::SA_W-1:0] sa,
  output logic [isd_pkg::LA_W-1:0] la,
  output logic [15:0] hd,
  output logic [5:0] st,
  output logic byte_hi_n,
  output logic aen,
  output logic refresh_n
);
  import isd_pkg::*;
  initial {bale, sa, la, hd, st, byte_hi_n, aen, refresh_n} = {1'h0, 20'h0_0000, 7'h00,
    16'h0000, 6'h3f, 3'h7};
  // One bus cycle; k selects the strobe, released lines show inverted levels
  task automatic cycle(input int k, input logic [23:0] a, input logic [15:0] d,
    input logic e, input logic r, input logic b, output logic sz);
    int n;
    @(posedge clock) #1;
    {la, sa, bale, aen, refresh_n, byte_hi_n} = {a[23:17], a[19:0], 1'h1, e, r, b};
    if (k == 2 || k == 3 || k == 5)
      hd = d;
    repeat (2) @(posedge clock) #1;
    bale = 1'h0;
    la = ~la;
    st = ~(6'h01 << k);
    repeat (5) @(posedge clock) #1;
    // Extended while the device holds ready low, bounded against a hang
    for (n = 0; n < 300 && chan_rdy_oe; n++) @(posedge clock) #1;
    sz = (k < 4) ? mem16_oe : io16_oe;
    @(posedge clock) #1;
    st = 6'h3f;
    hd = ~hd;
    repeat (6) @(posedge clock) #1;
    {aen, refresh_n, byte_hi_n} = 3'h7;
  endtask
endmodule

/* File: sim/isd_decode_test.sv */
`timescale 1ns/1ps
module isd_decode_test;
  import isd_pkg::*;
  logic clock = 0, rst_n = 0, bus_clk = 0, slot_16 = 1, wr_ready = 0, rd_done = 0;
  logic bale, byte_hi_n, aen, refresh_n, d_oe_lo, d_oe_hi, chan_rdy_oe, mem16_oe, io16_oe;
  logic wr_valid, wr_io, rd_req, rd_io, oe_q = 0, oeh_q = 0;
  logic mem_rd_n, sys_mem_rd_n, mem_wr_n, sys_mem_wr_n, io_rd_n, io_wr_n;
  logic [SA_W-1:0] sa;
  logic [LA_W-1:0] la;
  logic [5:0] st;
  logic [15:0] d_in, d_out, hd, wr_data, d_q, rd_data = 0;
  logic [ADDR_W-1:0] wr_addr, rd_addr, win_base [NUM_WIN], win_mask [NUM_WIN];
  logic [NUM_WIN-1:0] win_en = 4'h1, win_16 = 4'h1;
  logic [15:0] io_base = IO_BASE_DEF, io_span = IO_SPAN_DEF;
  integer seed = 61, num_errors = 0, n_checks = 0, n_rd = 0, exp_rd = 0, rs = 0, rc = 0;
  logic [17:0] wq [$];
  logic [15:0] rq [$];
  int kind_t [10] = '{0, 1, 2, 3, 4, 5, 4, 0, 5, 1};
  assign {io_wr_n, io_rd_n, sys_mem_wr_n, mem_wr_n, sys_mem_rd_n, mem_rd_n} = st;
  // Wire level per lane: the device wins while it drives
  assign d_in = {d_oe_hi ? d_out[15:8] : hd[15:8], d_oe_lo ? d_out[7:0] : hd[7:0]};
  always #5 clock = ~clock;
  always #80 bus_clk = ~bus_clk;
  isd_decode isd_decode_inst (.*);
  isd_host isd_host_inst (.*);
  task check(input logic [16:0] s, input logic [16:0] e);
    n_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task end_sim;
    if (num_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Processor side: slow or prompt read answers, write stalls at random
  always @(posedge clock)
  begin
    #1 rd_done = 0;
    wr_ready = 1'($random(seed));
    case (rs)
      0: if (rd_req) {rs, rc} = {32'd1, $random(seed) & 7};
      1: if (rc == 0) {rs, rd_done, rd_data} = {32'd2, 1'h1, 16'($random(seed))};
         else rc--;
      default: if (!rd_req) rs = 0;
    endcase
    if (rd_done)
      rq.push_back(rd_data);
  end
  // Results against the oldest note; read data is judged as the drive ends
  always @(posedge clock)
  begin
    logic [17:0] e;
    logic [15:0] m;
    if (wr_valid && wr_ready)
    begin
      e = wq.size() ? wq.pop_front() : 18'bx;
      m = e[17] ? 16'hffff : 16'h00ff;
      check({wr_io, wr_data & m}, {e[16], e[15:0] & m});
    end
    if (oe_q && !d_oe_lo)
    begin
      m = oeh_q ? 16'hffff : 16'h00ff;
      e = rq.size() ? rq.pop_front() : 18'bx;
      n_rd++;
      check(d_q & m, e[15:0] & m);
    end
    oe_q <= d_oe_lo;
    oeh_q <= d_oe_hi;
    d_q <= d_out;
  end
  initial
  begin
    #200000;
    num_errors++;
    end_sim;
  end
  // Pass 0: 16-bit slot and window; pass 1: 8-bit slot
  initial
  begin
    int p, k, kk, b;
    logic [23:0] a;
    logic [15:0] d;
    logic sz, hit;
    foreach (win_base[i])
      {win_base[i], win_mask[i]} = {i ? 24'h20_0000 : 24'h0c_0000, 24'h00_ffff};
    repeat (8) @(posedge clock);
    #1 rst_n = 1;
    for (p = 0; p < 2; p++)
    begin
      repeat (3) @(posedge clock);
      #1 {slot_16, win_16} = {!p[0], p ? 4'h0 : 4'h1};
      for (k = 0; k < 10; k++)
      begin
        {d, b, kk, hit} = {16'($random(seed)), p ? 1 : $random(seed), kind_t[k], k < 6};
        a = kk > 3 ? 24'h00_0290 : 24'h0c_0000 + ($random(seed) & 24'h00_fffe);
        if (k == 7)
          a = 24'h0e_0000;
        if (k == 8)
          a = 24'h00_0300;
        if (hit && (kk == 2 || kk == 3 || kk == 5))
          wq.push_back({!p[0] && !b[0], kk == 5, d});
        if (hit && (kk == 0 || kk == 1 || kk == 4))
          exp_rd++;
        isd_host_inst.cycle(kk, a, d, k == 6, k != 9, b[0], sz);
        if (kk < 4 || p == 0)
          check(17'(sz), 17'(hit && p == 0));
      end
    end
    repeat (50) @(posedge clock);
    check(17'(n_rd), 17'(exp_rd));
    check(17'(wq.size()), 17'h0_0000);
    end_sim;
  end
endmodule
bind isd_decode isd_decode_asserts isd_decode_asserts_inst (.*);
